/* inc/mlsd_defs.svh */
// Purpose: Constants of the multi-lane stripe and deskew source.
// Assumes: One lane bit time per ref_clk cycle.
// Notes: Included by the package and the design.
`ifndef MLSD_DEFS_SVH
`define MLSD_DEFS_SVH
`define MLSD_MAX_LANES 20
`define MLSD_MIN_LANES 4
`define MLSD_ELEM_SAMPLES 4
`define MLSD_ELEM_BITS 5
`define MLSD_PARITY_POS 3'h4
`define MLSD_REF_DIV 16
`define MLSD_REF_HALF_CYC (`MLSD_REF_DIV / 2)
`define MLSD_CLK_PERIOD_NS 100
`define MLSD_TXREF_PERIOD_NS 800
`define MLSD_TXREF_TIMEOUT_CYC ((2 * `MLSD_TXREF_PERIOD_NS) / `MLSD_CLK_PERIOD_NS)
`define MLSD_BUF_DEPTH 2'h2
`endif

/* inc/mlsd_pkg.sv */
// Purpose: Types of the multi-lane stripe and deskew source.
// Assumes: Constants come from mlsd_defs.svh.
// Notes: The block state is one packed struct; only the check flag started_q is a separate flop.
`include "mlsd_defs.svh"
package mlsd_pkg;
  typedef logic [`MLSD_MAX_LANES-1:0] mlsd_word_t;
  typedef struct packed {
    mlsd_word_t buf0;
    mlsd_word_t buf1;
    logic [1:0] cnt;
    logic in_ready;
    mlsd_word_t lanes;
    logic dsc;
    logic [2:0] elem;
    logic [2:0] bpos;
    logic [4:0] scnt;
    logic par;
    logic [2:0] div;
    logic refclk;
    logic optic_meta;
    logic optic_sync;
    logic txref_meta;
    logic txref_sync;
    logic txref_prev;
    logic [4:0] txref_tmr;
    logic txref_ok;
    logic alarm;
    logic [2:0] o_elem;
    logic [2:0] o_bpos;
    logic [4:0] o_idx;
    logic o_odd;
  } mlsd_state_t;
endpackage

/* src/mlsd_source.sv */
// Purpose: Receive-side source of a multi-lane link: striping, deskew channel, reference clock, alarm.
// Assumes: lane_count (4..20) and invert_en are static before reset is released.
// Notes: One lane bit time per ref_clk cycle; the transmit reference is only monitored.
// Functional notes
// - Earliest bit of each group goes to the top lane, latest to lane zero.
// - Each lane carries one bit out of every n stream bits.
// - With inversion on, lanes invert for five samples in odd elements.
// - Deskew channel repeats frames of two to five five-bit elements.
// - Two-element frame is even then odd.
// - Three-element frame is even, even, odd; two evens mark frame start.
// - Four-element frame is even, even, odd, odd.
// - Deskew samples walk lanes from the highest down to lane zero.
// - Leftover sample slots restart sampling from the highest lane.
// - Deskew samples are taken after lane inversion.
// - Reference clock runs at one sixteenth of lane rate, half duty.
// - This source provides the receive reference clock.
// - Receive reference clock paces the logic driving lanes and deskew channel.
// - Alarm output: zero is idle, one is receive alarm.
// - Alarm is raised while lane data is not from the incoming signal.
// - The source always drives the alarm output.
// - Transmit lanes and deskew channel are locked to the transmit reference.
// - One device in the transmit chain takes an external transmit reference.
// - Element is four samples then even or odd parity over them.
// - Elements: two for 4-8, three 9-12, four 13-16, five 17-20 lanes.
// - Five-element frame is even, even, odd, even, odd.
// - A new frame starts right after the previous one, without gaps.
`timescale 1ns/1ps
`default_nettype none
`include "mlsd_defs.svh"
module mlsd_source
  import mlsd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [4:0] lane_count,
  input wire logic invert_en,
  input wire logic optic_signal_ok,
  input wire logic tx_freq_ref_clk,
  input wire logic [`MLSD_MAX_LANES-1:0] in_word,
  input wire logic in_valid,
  output logic in_ready,
  output logic [`MLSD_MAX_LANES-1:0] rx_lane_bits,
  output logic rx_skew_ref_channel,
  output logic rx_freq_ref_clk,
  output logic rx_alarm_status,
  output logic tx_ref_present
);

  function automatic logic [2:0] elem_count(input logic [4:0] n);
    begin
      if (n <= 5'h08)
        elem_count = 3'h2;
      else if (n <= 5'h0C)
        elem_count = 3'h3;
      else if (n <= 5'h10)
        elem_count = 3'h4;
      else
        elem_count = 3'h5;
    end
  endfunction

  function automatic logic elem_odd(input logic [2:0] cnt, input logic [2:0] e);
    begin
      case (cnt)
        3'h2: elem_odd = (e == 3'h1);
        3'h3: elem_odd = (e == 3'h2);
        3'h4: elem_odd = (e >= 3'h2);
        3'h5: elem_odd = (e == 3'h2) || (e == 3'h4);
        default: elem_odd = 1'b0;
      endcase
    end
  endfunction

  mlsd_state_t s_q;
  mlsd_state_t s_d;
  logic [2:0] ecount;
  logic pop;
  logic push;
  mlsd_word_t word;
  mlsd_word_t lane_mask;
  logic odd_now;
  logic inv_now;
  logic [4:0] idx;
  logic smp;
  logic [1:0] c;

  assign ecount = elem_count(lane_count);

  always_comb
  begin
    s_d = s_q;
    c = s_q.cnt;
    push = in_valid && s_q.in_ready;
    pop = (s_q.cnt != 2'h0);
    word = pop ? s_q.buf0 : '0;
    // Two-entry buffer; the lanes drain one group per bit time.
    if (pop)
    begin
      s_d.buf0 = s_q.buf1;
      c = c - 2'h1;
    end
    if (push)
    begin
      if (c == 2'h0)
        s_d.buf0 = in_word;
      else
        s_d.buf1 = in_word;
      c = c + 2'h1;
    end
    s_d.cnt = c;
    s_d.in_ready = (c != `MLSD_BUF_DEPTH);
    // Lanes above lane_count stay low so the sink never sees stale bits.
    lane_mask = mlsd_word_t'((`MLSD_MAX_LANES'(1) << lane_count) - `MLSD_MAX_LANES'(1));
    odd_now = elem_odd(ecount, s_q.elem);
    inv_now = invert_en && odd_now;
    // Fill is never inverted, so an underrun always shows all-zero lanes to the sink.
    if (pop)
      s_d.lanes = (word ^ {`MLSD_MAX_LANES{inv_now}}) & lane_mask;
    else
      s_d.lanes = '0;
    idx = lane_count - 5'h01 - s_q.scnt;
    smp = s_d.lanes[idx];
    if (s_q.bpos == `MLSD_PARITY_POS)
    begin
      s_d.dsc = s_q.par ^ odd_now;
      if (s_q.elem == ecount - 3'h1)
      begin
        s_d.elem = 3'h0;
        s_d.scnt = 5'h00;
      end
      else
        s_d.elem = s_q.elem + 3'h1;
      s_d.bpos = 3'h0;
    end
    else
    begin
      s_d.dsc = smp;
      s_d.par = (s_q.bpos == 3'h0) ? smp : (s_q.par ^ smp);
      s_d.scnt = (s_q.scnt == lane_count - 5'h01) ? 5'h00 : (s_q.scnt + 5'h01);
      s_d.bpos = s_q.bpos + 3'h1;
    end
    s_d.o_elem = s_q.elem;
    s_d.o_bpos = s_q.bpos;
    s_d.o_idx = idx;
    s_d.o_odd = odd_now;
    // Lane timing and this divider share one counter base, so they stay frequency locked.
    s_d.div = s_q.div + 3'h1;
    if (s_q.div == 3'(`MLSD_REF_HALF_CYC - 1))
      s_d.refclk = ~s_q.refclk;
    s_d.optic_meta = optic_signal_ok;
    s_d.optic_sync = s_q.optic_meta;
    // An empty buffer means the lanes carry fill, not received data.
    s_d.alarm = ~s_q.optic_sync | ~pop;
    s_d.txref_meta = tx_freq_ref_clk;
    s_d.txref_sync = s_q.txref_meta;
    s_d.txref_prev = s_q.txref_sync;
    if (s_q.txref_sync != s_q.txref_prev)
      s_d.txref_tmr = 5'h00;
    else if (s_q.txref_tmr != 5'h1F)
      s_d.txref_tmr = s_q.txref_tmr + 5'h01;
    s_d.txref_ok = (s_d.txref_tmr < 5'(`MLSD_TXREF_TIMEOUT_CYC));
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign in_ready = s_q.in_ready;
  assign rx_lane_bits = s_q.lanes;
  assign rx_skew_ref_channel = s_q.dsc;
  assign rx_freq_ref_clk = s_q.refclk;
  assign rx_alarm_status = s_q.alarm;
  assign tx_ref_present = s_q.txref_ok;

  // Checks.
  logic started_q;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      started_q <= 1'b0;
    else
      started_q <= 1'b1;
  end

  AST_LANE_STRIPE: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.cnt != 2'h0 && !inv_now) |=> (rx_lane_bits == ($past(s_q.buf0) & $past(lane_mask))))
    else $error("Lane word does not match the buffered group.");

  AST_INV_ODD: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && invert_en && odd_now && s_q.cnt != 2'h0)
      |=> (rx_lane_bits == (~$past(s_q.buf0) & $past(lane_mask))))
    else $error("Lanes not inverted during an odd element.");

  AST_PARITY: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.o_bpos == `MLSD_PARITY_POS && $past(s_q.o_bpos, 4) == 3'h0)
      |-> (rx_skew_ref_channel == ($past(rx_skew_ref_channel, 1) ^ $past(rx_skew_ref_channel, 2)
        ^ $past(rx_skew_ref_channel, 3) ^ $past(rx_skew_ref_channel, 4) ^ s_q.o_odd)))
    else $error("Deskew parity bit is wrong.");

  AST_FRAME_SHAPE: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && (s_q.o_elem == 3'h0 || (ecount > 3'h2 && s_q.o_elem == 3'h1)))
      |-> !s_q.o_odd && (s_q.o_elem != ecount - 3'h1))
    else $error("Frame does not open with even elements.");

  AST_FRAME_END_ODD: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.o_elem == ecount - 3'h1) |-> s_q.o_odd)
    else $error("Frame does not end with an odd element.");

  AST_SAMPLE: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.o_bpos != `MLSD_PARITY_POS) |-> (rx_skew_ref_channel == rx_lane_bits[s_q.o_idx]))
    else $error("Deskew sample does not match its lane.");

  AST_SAMPLE_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.o_elem == 3'h0 && s_q.o_bpos == 3'h0) |-> (s_q.o_idx == lane_count - 5'h01))
    else $error("Frame does not start sampling on the top lane.");

  AST_CONTINUOUS: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.o_bpos == `MLSD_PARITY_POS && s_q.o_elem == ecount - 3'h1)
      |=> (s_q.o_elem == 3'h0 && s_q.o_bpos == 3'h0))
    else $error("Next frame does not follow at once.");

  AST_REFCLK: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(rx_freq_ref_clk) |-> rx_freq_ref_clk [*8] ##1 !rx_freq_ref_clk [*8])
    else $error("Reference clock is not one sixteenth of the lane rate.");

  AST_ALARM: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.cnt == 2'h0 || !s_q.optic_sync) |=> rx_alarm_status)
    else $error("Alarm not raised for fill data.");

  AST_TXREF: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.txref_tmr == 5'h1F) |-> !tx_ref_present)
    else $error("Transmit reference reported while still.");

  AST_UNDERRUN_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.cnt == 2'h0)
      |=> (rx_lane_bits == '0))
    else $error("Lanes not zero during an underrun.");

  AST_LANE_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    started_q
      |-> ((rx_lane_bits & ~lane_mask) == '0))
    else $error("Lane above the lane count is driven.");

  AST_ALARM_IDLE: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.cnt != 2'h0 && s_q.optic_sync)
      |=> !rx_alarm_status)
    else $error("Alarm raised while lanes carry received data.");

  AST_READY_FULL: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.cnt == `MLSD_BUF_DEPTH)
      |-> !in_ready)
    else $error("Ready offered with a full buffer.");

  AST_CNT_RANGE: assert property (@(posedge ref_clk) disable iff (reset)
    started_q
      |-> (s_q.cnt <= `MLSD_BUF_DEPTH))
    else $error("Buffer count out of range.");

  AST_BPOS_RANGE: assert property (@(posedge ref_clk) disable iff (reset)
    started_q
      |-> (s_q.bpos <= `MLSD_PARITY_POS))
    else $error("Element bit position out of range.");

  AST_ELEM_RANGE: assert property (@(posedge ref_clk) disable iff (reset)
    started_q
      |-> (s_q.elem < ecount))
    else $error("Element index beyond the frame length.");

  AST_SCNT_RANGE: assert property (@(posedge ref_clk) disable iff (reset)
    started_q
      |-> (s_q.scnt < lane_count))
    else $error("Sample lane counter beyond the lane count.");

  AST_ECOUNT_LOW: assert property (@(posedge ref_clk) disable iff (reset)
    (lane_count <= 5'h08)
      |-> (ecount == 3'h2))
    else $error("Wrong element count for a narrow link.");

  AST_ECOUNT_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
    (lane_count >= 5'h11)
      |-> (ecount == 3'h5))
    else $error("Wrong element count for a wide link.");

  AST_REFCLK_LOW: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(rx_freq_ref_clk)
      |-> !rx_freq_ref_clk [*8] ##1 rx_freq_ref_clk)
    else $error("Reference clock low phase is not eight cycles.");

  AST_DIV_TOGGLE: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.div == 3'(`MLSD_REF_HALF_CYC - 1))
      |=> (rx_freq_ref_clk != $past(rx_freq_ref_clk)))
    else $error("Reference clock did not toggle at the divider end.");

  AST_PARITY_WRAP: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.o_bpos == `MLSD_PARITY_POS)
      |=> (s_q.o_bpos == 3'h0))
    else $error("Parity bit not followed by a new element.");

  AST_BPOS_STEP: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.o_bpos != `MLSD_PARITY_POS)
      |=> (s_q.o_bpos == $past(s_q.o_bpos) + 3'h1))
    else $error("Element bit position skipped.");

  AST_ELEM_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && s_q.o_bpos != `MLSD_PARITY_POS)
      |=> $stable(s_q.o_elem))
    else $error("Element changed before its parity bit.");

  AST_SCNT_RESTART: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.bpos == `MLSD_PARITY_POS && s_q.elem == ecount - 3'h1)
      |=> (s_q.scnt == 5'h00))
    else $error("Sampling does not restart at the top lane.");

  AST_OPTIC_SYNC: assert property (@(posedge ref_clk) disable iff (reset)
    started_q
      |-> (s_q.optic_sync == $past(s_q.optic_meta)))
    else $error("Signal status synchroniser broken.");

  AST_TXREF_TOGGLE: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.txref_sync != s_q.txref_prev)
      |=> tx_ref_present)
    else $error("Transmit reference edge not reported.");

  AST_EVEN_NO_INVERT: assert property (@(posedge ref_clk) disable iff (reset)
    (started_q && !odd_now && s_q.cnt != 2'h0)
      |=> (rx_lane_bits == ($past(s_q.buf0) & $past(lane_mask))))
    else $error("Lanes inverted outside an odd element.");

  COV_FRAME_WRAP: cover property (@(posedge ref_clk) disable iff (reset)
    s_q.o_elem == ecount - 3'h1 ##5 s_q.o_elem == 3'h0);
  COV_INVERT: cover property (@(posedge ref_clk) disable iff (reset) invert_en && odd_now && pop);
  COV_ALARM: cover property (@(posedge ref_clk) disable iff (reset) $rose(rx_alarm_status));
  COV_BUF_FULL: cover property (@(posedge ref_clk) disable iff (reset) s_q.cnt == `MLSD_BUF_DEPTH);
  COV_UNDERRUN: cover property (@(posedge ref_clk) disable iff (reset)
    started_q && s_q.cnt == 2'h0);

endmodule
`default_nettype wire

/* bench/mlsd_sink_model.sv */
// Purpose: Sink side model: syncs the alarm, checks deskew element parity.
// Assumes: Frame starts at the first edge after reset release.
// Notes: Counts parity faults only; it never stalls the source.
`timescale 1ns/1ps
`default_nettype none
module mlsd_sink_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [4:0] lane_count,
  input wire logic rx_skew_ref_channel,
  input wire logic rx_alarm_status,
  output logic alarm_synced,
  output int par_errs
);
  logic meta;
  logic acc;
  int cyc;
  int ec;
  int p;
  function automatic logic odd_el(int c, int e);
    return (c == 2 && e == 1) || (c == 3 && e == 2) || (c == 4 && e >= 2) || (c == 5 && (e == 2 || e == 4));
  endfunction
  // Two flops, since the alarm is asynchronous to this side.
  always @(posedge ref_clk)
  begin
    meta <= rx_alarm_status;
    alarm_synced <= meta;
    ec = (lane_count <= 8) ? 2 : (lane_count + 3) / 4;
    if (reset)
    begin
      cyc = 0;
      acc = 0;
      par_errs = 0;
    end
    else
    begin
      if (cyc >= 1)
      begin
        p = (cyc - 1) % (5 * ec);
        if (p % 5 < 4)
          acc ^= rx_skew_ref_channel;
        else
        begin
          if (rx_skew_ref_channel !== (acc ^ odd_el(ec, p / 5)))
            par_errs++;
          acc = 0;
        end
      end
      cyc++;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: Self-checking bench of the lane source.
// Assumes: Lane word and deskew bit change once per ref_clk cycle.
// Notes: Test words keep bit 0 high and the top lane low, so zero lanes mark an underrun.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mlsd_pkg::*;
  logic ref_clk, reset, invert_en, optic_signal_ok, tx_freq_ref_clk, in_valid, stream, txrun, acc;
  logic [4:0] lane_count;
  mlsd_word_t in_word, mask, ew;
  logic in_ready, dsc, rck, alarm, txp, alarm_s;
  mlsd_word_t lanes;
  int fail_count, n_checks, cyc, k, ec, p, e, refused, perr;
  mlsd_word_t q[$];
  mlsd_source uut (.ref_clk(ref_clk), .reset(reset), .lane_count(lane_count), .invert_en(invert_en),
    .optic_signal_ok(optic_signal_ok), .tx_freq_ref_clk(tx_freq_ref_clk), .in_word(in_word),
    .in_valid(in_valid), .in_ready(in_ready), .rx_lane_bits(lanes), .rx_skew_ref_channel(dsc),
    .rx_freq_ref_clk(rck), .rx_alarm_status(alarm), .tx_ref_present(txp));
  mlsd_sink_model sink (.ref_clk(ref_clk), .reset(reset), .lane_count(lane_count),
    .rx_skew_ref_channel(dsc), .rx_alarm_status(alarm), .alarm_synced(alarm_s), .par_errs(perr));
  initial
  begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    tx_freq_ref_clk = 0;
    #13;
    forever #400 if (txrun) tx_freq_ref_clk = ~tx_freq_ref_clk;
  end
  task automatic chk(string nm, mlsd_word_t x, mlsd_word_t g);
    n_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // A word is held until an edge takes it.
  always @(posedge ref_clk)
  begin
    cyc <= reset ? 0 : cyc + 1;
    if (reset)
      q.delete();
    else if (in_valid && in_ready)
    begin
      q.push_back(in_word & mask);
      k++;
      in_word <= ((20'h9E3B7 ^ (k * 20'h0C5A1)) & ~(20'h1 << (lane_count - 1))) | 20'h1;
    end
    else if (in_valid)
      refused++;
    in_valid <= stream;
  end
  always @(negedge ref_clk)
  if (cyc >= 1)
  begin
    p = (cyc - 1) % (5 * ec);
    e = p / 5;
    chk("ref_clk_out", 20'((cyc >> 3) & 1), 20'(rck));
    if (p % 5 < 4)
    begin
      chk("deskew_sample", 20'(lanes[lane_count - 1 - ((e * 4 + p % 5) % lane_count)]), 20'(dsc));
      acc ^= dsc;
    end
    else
    begin
      chk("deskew_parity", 20'(acc ^ sink.odd_el(ec, e)), 20'(dsc));
      acc = 0;
    end
    if (lanes !== 0)
    begin
      ew = (q.size() > 0) ? q.pop_front() : 20'hFFFFF;
      chk("lanes", ew ^ ((invert_en && sink.odd_el(ec, e)) ? mask : 20'h0), lanes);
    end
  end
  else
    acc = 0;
  task automatic wait_cyc(int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic run_cfg(logic [4:0] n, logic inv);
    @(posedge ref_clk);
    reset <= 1;
    stream <= 0;
    @(posedge ref_clk);
    lane_count <= n;
    invert_en <= inv;
    mask <= (20'h1 << n) - 1;
    ec <= (n <= 8) ? 2 : (n + 3) / 4;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("lanes_in_reset", 20'h0, lanes);
    @(posedge ref_clk);
    reset <= 0;
    stream <= 1;
    refused = 0;
    wait_cyc(150);
    @(negedge ref_clk);
    chk("refused", 20'h0, 20'(refused));
    chk("alarm_idle", 20'h0, 20'(alarm));
    chk("parity_errors", 20'h0, 20'(perr));
  endtask
  task automatic gap_and_loss();
    @(posedge ref_clk);
    stream <= 0;
    wait_cyc(8);
    @(negedge ref_clk);
    chk("underrun_alarm", 20'h1, 20'(alarm));
    chk("underrun_lanes", 20'h0, lanes);
    @(posedge ref_clk);
    stream <= 1;
    optic_signal_ok <= 0;
    wait_cyc(10);
    @(negedge ref_clk);
    chk("optic_alarm", 20'h1, 20'(alarm_s));
    @(posedge ref_clk);
    optic_signal_ok <= 1;
    wait_cyc(10);
    @(negedge ref_clk);
    chk("alarm_clear", 20'h0, 20'(alarm));
  endtask
  task automatic txref_loss();
    chk("txref_on", 20'h1, 20'(txp));
    @(posedge ref_clk);
    txrun <= 0;
    wait_cyc(30);
    @(negedge ref_clk);
    chk("txref_off", 20'h0, 20'(txp));
    @(posedge ref_clk);
    txrun <= 1;
    wait_cyc(30);
    @(negedge ref_clk);
    chk("txref_back", 20'h1, 20'(txp));
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    {reset, stream, in_valid, invert_en, optic_signal_ok, txrun} = 6'h2B;
    {fail_count, n_checks, k, refused, cyc} = '0;
    {lane_count, in_word, mask, ec} = {5'h04, 20'h00001, 20'h0000F, 32'h2};
    run_cfg(5'h04, 1'b0);
    run_cfg(5'h04, 1'b1);
    run_cfg(5'h0A, 1'b1);
    run_cfg(5'h0D, 1'b1);
    run_cfg(5'h14, 1'b1);
    gap_and_loss();
    txref_loss();
    print_verdict();
  end
endmodule
`default_nettype wire
